// >>> logic/smts_select.sv
`timescale 1ns/1ps
`default_nettype none
module smts_select #(
    parameter int unsigned WORD_W = 10
) (
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    input  wire smts_pkg::smts_ctrl_t    ctrl_pins,
    input  wire smts_pkg::smts_sync_in_t sync_in,
    input  wire logic [WORD_W-1:0]       din_hi,
    input  wire logic [WORD_W-1:0]       din_lo,
    output var  smts_pkg::smts_mode_t    op_mode,
    output var  smts_pkg::smts_src_t     timing_src,
    output var  logic                    bus_wide,
    output var  smts_pkg::smts_enables_t enables,
    output var  smts_pkg::smts_timing_t  timing_out,
    output var  logic                    trs_seen,
    output var  logic [WORD_W-1:0]       dout_hi,
    output var  logic [WORD_W-1:0]       dout_lo
);
    import smts_pkg::*;

    if (WORD_W != TRS_W) begin : g_bad_word
        $error("smts_select needs a word width equal to the TRS word width.");
    end

    function automatic smts_mode_t mode_of(input smts_ctrl_t c);
        if (c.video_processing_en) begin
            mode_of = MODE_SMPTE;
        end else if (c.async_stream_sel) begin
            mode_of = MODE_ASI;
        end else begin
            mode_of = MODE_THROUGH;
        end
    endfunction : mode_of

    function automatic smts_src_t src_of(input smts_ctrl_t c);
        if (c.embedded_sync_sel) begin
            src_of = SRC_TRS;
        end else if (c.ext_sync_style_sel) begin
            src_of = SRC_861;
        end else begin
            src_of = SRC_HVF;
        end
    endfunction : src_of

    // Control pins are static by contract, so a plain two-flop pass is enough. [RULE11]
    smts_ctrl_t ctrl_s;

    smts_sync #(
        .WIDTH (CTRL_W)
    ) u_ctrl_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in (ctrl_pins),
        .sync_out (ctrl_s)
    );

    smts_mode_t    next_op_mode;
    smts_src_t     next_timing_src;
    logic          next_bus_wide;
    smts_enables_t next_enables;

    always_comb begin
        next_op_mode    = mode_of(ctrl_s);                          // [RULE5] [RULE6] [RULE7]
        next_timing_src = src_of(ctrl_s);                           // [RULE1] [RULE2] [RULE3]
        next_bus_wide   = ctrl_s.bus_width_sel;                     // [RULE4]
        // One enable gates every SMPTE function together. [RULE9]
        next_enables.scramble_en   = ctrl_s.video_processing_en;   // [RULE7] [RULE8]
        next_enables.ioproc_en     = ctrl_s.video_processing_en;   // [RULE7] [RULE8]
        next_enables.trs_insert_en = ctrl_s.video_processing_en;   // [RULE9]
        next_enables.edh_en        = ctrl_s.video_processing_en;   // [RULE9]
        next_enables.nrzi_en       = ctrl_s.video_processing_en;   // [RULE9]
        next_enables.asi_encode_en = next_op_mode == MODE_ASI;     // [RULE5]
        next_enables.asi_align_en  = next_op_mode == MODE_ASI;     // [RULE5]
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            op_mode    <= MODE_THROUGH;
            timing_src <= SRC_HVF;
            bus_wide   <= 1'b0;
            enables    <= '0;
        end else begin
            op_mode    <= next_op_mode;
            timing_src <= next_timing_src;
            bus_wide   <= next_bus_wide;
            enables    <= next_enables;
        end
    end

    // Embedded sync: a short word history finds the preamble in either bus width.
    logic [HIST_DEPTH-1:0][WORD_W-1:0] hist;
    logic [HIST_DEPTH-1:0][WORD_W-1:0] next_hist;
    logic                              trs_h;
    logic                              trs_v;
    logic                              trs_f;
    logic                              next_trs_h;
    logic                              next_trs_v;
    logic                              next_trs_f;
    logic                              next_trs_seen;
    logic                              hit_wide;
    logic                              hit_narrow;
    logic                              vsync_d;
    logic                              field_861;
    logic                              next_vsync_d;
    logic                              next_field_861;

    always_comb begin
        next_hist  = {hist[HIST_DEPTH-2:0], din_hi};
        hit_wide   = hist[2] == TRS_ONES && hist[1] == TRS_ZEROS && hist[0] == TRS_ZEROS;
        hit_narrow = hist[4] == TRS_ONES && hist[3] == TRS_ZEROS && hist[2] == TRS_ZEROS
                     && hist[1] == TRS_ZEROS && hist[0] == TRS_ZEROS;
        next_trs_seen = bus_wide ? hit_wide : hit_narrow;           // [RULE4]
        next_trs_h    = trs_h;
        next_trs_v    = trs_v;
        next_trs_f    = trs_f;
        if (next_trs_seen) begin                                    // [RULE3]
            next_trs_h = din_hi[XYZ_H_BIT];
            next_trs_v = din_hi[XYZ_V_BIT];
            next_trs_f = din_hi[XYZ_F_BIT];
        end
        next_vsync_d   = sync_in.vsync;
        next_field_861 = field_861 ^ (sync_in.vsync & ~vsync_d);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hist      <= '0;
            trs_h     <= 1'b0;
            trs_v     <= 1'b0;
            trs_f     <= 1'b0;
            trs_seen  <= 1'b0;
            vsync_d   <= 1'b0;
            field_861 <= 1'b0;
        end else begin
            hist      <= next_hist;
            trs_h     <= next_trs_h;
            trs_v     <= next_trs_v;
            trs_f     <= next_trs_f;
            trs_seen  <= next_trs_seen;
            vsync_d   <= next_vsync_d;
            field_861 <= next_field_861;
        end
    end

    smts_timing_t      next_timing_out;
    logic [WORD_W-1:0] next_dout_hi;
    logic [WORD_W-1:0] next_dout_lo;

    always_comb begin
        unique case (next_timing_src)
            SRC_HVF: begin                                          // [RULE1]
                next_timing_out = '{h_blank: sync_in.h_in, v_blank: sync_in.v_in,
                                    field: sync_in.f_in};
            end
            SRC_861: begin                                          // [RULE2]
                next_timing_out = '{h_blank: sync_in.hsync | ~sync_in.de,
                                    v_blank: sync_in.vsync, field: next_field_861};
            end
            SRC_TRS: begin                                          // [RULE3]
                next_timing_out = '{h_blank: next_trs_h, v_blank: next_trs_v,
                                    field: next_trs_f};
            end
            default: begin
                next_timing_out = '0;
            end
        endcase
        next_dout_hi = din_hi;
        // Lower word is chroma or pass-through data only on a wide bus outside async mode.
        if (next_bus_wide && next_op_mode != MODE_ASI) begin        // [RULE10]
            next_dout_lo = din_lo;
        end else begin
            next_dout_lo = '0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            timing_out <= '0;
            dout_hi    <= '0;
            dout_lo    <= '0;
        end else begin
            timing_out <= next_timing_out;
            dout_hi    <= next_dout_hi;
            dout_lo    <= next_dout_lo;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    AST_HVF_SOURCE: assert property ( // [RULE1]
        !ctrl_s.embedded_sync_sel && !ctrl_s.ext_sync_style_sel
        |=> timing_src == SRC_HVF && timing_out.v_blank == $past(sync_in.v_in))
        else $error("HVF timing not selected.");
    AST_861_SOURCE: assert property ( // [RULE2]
        !ctrl_s.embedded_sync_sel && ctrl_s.ext_sync_style_sel
        |=> timing_src == SRC_861 && timing_out.v_blank == $past(sync_in.vsync))
        else $error("HSYNC/VSYNC/DE timing not selected.");
    AST_TRS_SOURCE: assert property ( // [RULE3]
        ctrl_s.embedded_sync_sel
        |=> timing_src == SRC_TRS && timing_out.field == trs_f)
        else $error("Embedded TRS timing not selected.");
    // A full wide header in the history must be caught and its H and F bits taken.
    AST_TRS_CAPTURE: assert property ( // [RULE3]
        ctrl_s.embedded_sync_sel && bus_wide && hist[2] == TRS_ONES
        && hist[1] == TRS_ZEROS && hist[0] == TRS_ZEROS
        |=> trs_seen && timing_out.h_blank == $past(din_hi[XYZ_H_BIT])
        && timing_out.field == $past(din_hi[XYZ_F_BIT]))
        else $error("Embedded TRS header not captured.");
    AST_BUS_WIDTH: assert property ( // [RULE4]
        ctrl_s.bus_width_sel ##1 ctrl_s.bus_width_sel
        |=> bus_wide)
        else $error("Bus width does not follow its select.");
    AST_ASI_MODE: assert property ( // [RULE5]
        ctrl_s.async_stream_sel && !ctrl_s.video_processing_en
        |=> op_mode == MODE_ASI && enables.asi_align_en && !enables.scramble_en)
        else $error("Async stream mode not entered.");
    AST_THROUGH_MODE: assert property ( // [RULE6]
        !ctrl_s.async_stream_sel && !ctrl_s.video_processing_en
        |=> op_mode == MODE_THROUGH && enables == '0)
        else $error("Data-through mode not plain.");
    AST_PROC_ON: assert property ( // [RULE7]
        ctrl_s.video_processing_en
        |=> op_mode == MODE_SMPTE && enables.scramble_en && enables.ioproc_en)
        else $error("Processing on but scrambling off.");
    AST_PROC_OFF: assert property ( // [RULE8]
        !ctrl_s.video_processing_en
        |=> !enables.scramble_en && !enables.ioproc_en)
        else $error("Processing off but features active.");
    AST_JOINT_GATE: assert property ( // [RULE9]
        enables.scramble_en == enables.edh_en
        && enables.edh_en == enables.trs_insert_en && enables.nrzi_en == enables.ioproc_en
        && enables.scramble_en == enables.ioproc_en)
        else $error("SMPTE functions not gated together.");
    AST_LOWER_WORD: assert property ( // [RULE10]
        (ctrl_s.async_stream_sel && !ctrl_s.video_processing_en)
        || !ctrl_s.bus_width_sel |=> dout_lo == '0)
        else $error("Lower word not blanked.");
    AST_CHROMA_PASS: assert property ( // [RULE10]
        ctrl_s.bus_width_sel && ctrl_s.video_processing_en
        |=> dout_lo == $past(din_lo))
        else $error("Chroma word not passed.");

    COV_SMPTE: cover property (op_mode == MODE_SMPTE ##1 op_mode == MODE_SMPTE);
    COV_ASI: cover property (op_mode == MODE_ASI && bus_wide);
    COV_THROUGH: cover property (op_mode == MODE_THROUGH && timing_src == SRC_861);
    COV_TRS: cover property (timing_src == SRC_TRS && trs_seen);

endmodule : smts_select
`default_nettype wire

// >>> logic/smts_pkg.sv
// Function
// RULE1: With embedded sync off and the external sync style low, timing comes from the H, V and F inputs.
// RULE2: With embedded sync off and the external sync style high, timing comes from HSYNC, VSYNC and DE.
// RULE3: With embedded sync on, timing comes from TRS words in the video stream, whatever the style.
// RULE4: The bus width select chooses a wide word or a narrow multiplexed word on the parallel bus.
// RULE5: Async stream select high with processing off gives async word alignment, processing and sending.
// RULE6: Processing off and async stream select low gives plain data-through with no processing.
// RULE7: Processing on applies scrambling and the video input/output processing features.
// RULE8: Processing off gives no scrambling and no input/output processing features at all.
// RULE9: The processing enable turns every encode, decode, scramble and EDH function on or off together.
// RULE10: The lower word carries chroma in wide mode with processing, is ignored in async mode, unused narrow.
// RULE11: The upstream logic keeps all select inputs static except during reset or standby.
package smts_pkg;

    localparam int unsigned TRS_W       = 10;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned HIST_DEPTH  = 5;

    localparam logic [TRS_W-1:0] TRS_ONES  = 10'h3FF;
    localparam logic [TRS_W-1:0] TRS_ZEROS = 10'h000;

    localparam int unsigned XYZ_F_BIT = 8;
    localparam int unsigned XYZ_V_BIT = 7;
    localparam int unsigned XYZ_H_BIT = 6;

    typedef enum logic [1:0] {
        MODE_THROUGH = 2'b00,
        MODE_ASI     = 2'b01,
        MODE_SMPTE   = 2'b10
    } smts_mode_t;

    typedef enum logic [1:0] {
        SRC_HVF = 2'b00,
        SRC_861 = 2'b01,
        SRC_TRS = 2'b10
    } smts_src_t;

    typedef struct packed {
        logic video_processing_en;
        logic async_stream_sel;
        logic bus_width_sel;
        logic embedded_sync_sel;
        logic ext_sync_style_sel;
    } smts_ctrl_t;

    localparam int unsigned CTRL_W = $bits(smts_ctrl_t);
    localparam smts_ctrl_t CTRL_RESET = '0;

    typedef struct packed {
        logic h_in;
        logic v_in;
        logic f_in;
        logic hsync;
        logic vsync;
        logic de;
    } smts_sync_in_t;

    typedef struct packed {
        logic h_blank;
        logic v_blank;
        logic field;
    } smts_timing_t;

    typedef struct packed {
        logic scramble_en;
        logic ioproc_en;
        logic trs_insert_en;
        logic edh_en;
        logic nrzi_en;
        logic asi_encode_en;
        logic asi_align_en;
    } smts_enables_t;

endpackage : smts_pkg

// >>> logic/smts_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for the static control pins.
module smts_sync #(
    parameter int unsigned WIDTH = 5
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    import smts_pkg::*;

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    if (WIDTH < 1) begin : g_bad_width
        $error("smts_sync needs a width of at least one.");
    end

    always_comb begin
        next_meta     = async_in;
        next_sync_out = meta;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= next_meta;
            sync_out <= next_sync_out;
        end
    end

endmodule : smts_sync
`default_nettype wire

// >>> verification/smts_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// Upstream source logic: owns the select pins and presents one word set per call.
module smts_src_model (
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    output var  smts_pkg::smts_ctrl_t    ctrl_pins,
    output var  smts_pkg::smts_sync_in_t sync_in,
    output var  logic [9:0]              din_hi,
    output var  logic [9:0]              din_lo
);
    import smts_pkg::*;

    initial begin
        ctrl_pins = CTRL_RESET;
        sync_in = '0;
        din_hi = 10'h200;
        din_lo = 10'h000;
    end

    task automatic set_ctrl(input smts_ctrl_t c);
        if (reset === 1'b1) begin
            ctrl_pins = c;
        end else begin
            $display("model: select change held back outside reset");
        end
    endtask : set_ctrl

    task automatic drive(input smts_sync_in_t s, input logic [9:0] hi, input logic [9:0] lo);
        @(negedge clk_sys);
        sync_in = s;
        din_hi = hi;
        din_lo = lo;
    endtask : drive
endmodule : smts_src_model
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import smts_pkg::*;

    logic           clk_sys = 1'b0;
    logic           reset = 1'b1;
    smts_ctrl_t     ctrl_pins;
    smts_sync_in_t  sync_in;
    logic [9:0]     din_hi;
    logic [9:0]     din_lo;
    smts_mode_t     op_mode;
    smts_src_t      timing_src;
    logic           bus_wide;
    smts_enables_t  enables;
    smts_timing_t   timing_out;
    logic           trs_seen;
    logic [9:0]     dout_hi;
    logic [9:0]     dout_lo;
    int             errors = 0;
    int             cmp_count = 0;
    int             cycles = 0;

    always #5 clk_sys = ~clk_sys;

    smts_src_model src (.clk_sys(clk_sys), .reset(reset), .ctrl_pins(ctrl_pins),
        .sync_in(sync_in), .din_hi(din_hi), .din_lo(din_lo));

    smts_select #(.WORD_W(10)) DUT (.clk_sys(clk_sys), .reset(reset), .ctrl_pins(ctrl_pins),
        .sync_in(sync_in), .din_hi(din_hi), .din_lo(din_lo), .op_mode(op_mode),
        .timing_src(timing_src), .bus_wide(bus_wide), .enables(enables),
        .timing_out(timing_out), .trs_seen(trs_seen), .dout_hi(dout_hi), .dout_lo(dout_lo));

    task automatic summarize;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    // Selects move only under reset; mode outputs settle three edges after release.
    task automatic cfg(input logic p, input logic a, input logic w, input logic e, input logic s);
        @(negedge clk_sys);
        reset = 1'b1;
        src.set_ctrl(smts_ctrl_t'({p, a, w, e, s}));
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask : cfg

    task automatic test_modes;
        logic       p;
        logic       a;
        logic       w;
        smts_mode_t exp_mode;
        for (int i = 0; i < 8; i++) begin
            {p, a, w} = i[2:0];
            cfg(p, a, w, 1'b0, 1'b0);
            exp_mode = p ? MODE_SMPTE : (a ? MODE_ASI : MODE_THROUGH);
            chk("op_mode", exp_mode, op_mode);
            chk("enables", {p, p, p, p, p, ~p & a, ~p & a}, enables);
            chk("bus_wide", w, bus_wide);
            chk("scramble_en", p, enables.scramble_en);
            chk("edh_en", p, enables.edh_en);
            chk("nrzi_en", p, enables.nrzi_en);
            chk("asi_align_en", ~p & a, enables.asi_align_en);
            src.drive('0, 10'h2AA, 10'h155);
            @(negedge clk_sys);
            chk("dout_hi", 10'h2AA, dout_hi);
            chk("dout_lo", (w & (p | ~a)) ? 10'h155 : 10'h000, dout_lo);
        end
    endtask : test_modes

    task automatic test_hvf;
        cfg(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        chk("timing_src", SRC_HVF, timing_src);
        for (int i = 0; i < 8; i++) begin
            src.drive(smts_sync_in_t'({i[2:0], 3'b100}), 10'h200, 10'h000);
            @(negedge clk_sys);
            chk("timing_hvf", i[2:0], timing_out);
        end
    endtask : test_hvf

    task automatic test_861;
        logic fld;
        logic pv;
        fld = 1'b0;
        pv = 1'b0;
        cfg(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        chk("timing_src", SRC_861, timing_src);
        for (int i = 0; i < 8; i++) begin
            // The H, V, F pins carry the inverse so a wrong source shows.
            src.drive(smts_sync_in_t'({~i[2:0], i[2:0]}), 10'h200, 10'h000);
            if (i[1] && !pv) begin
                fld = ~fld;
            end
            pv = i[1];
            repeat (2) @(negedge clk_sys);
            chk("timing_861", {i[2] | ~i[0], i[1], fld}, timing_out);
        end
    endtask : test_861

    task automatic send_trs(input logic [9:0] xyz, input logic [2:0] exp, input int nz);
        int k;
        src.drive('1, 10'h3FF, 10'h000);
        repeat (nz) src.drive('1, 10'h000, 10'h000);
        src.drive('1, xyz, 10'h000);
        src.drive('1, 10'h200, 10'h000);
        k = 0;
        while (trs_seen !== 1'b1 && k < 3) begin
            @(negedge clk_sys);
            k++;
        end
        chk("trs_seen", 1'b1, trs_seen);
        chk("timing_trs", exp, timing_out);
        @(negedge clk_sys);
        chk("trs_pulse", 1'b0, trs_seen);
    endtask : send_trs

    task automatic test_trs;
        cfg(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        chk("timing_src", SRC_TRS, timing_src);
        send_trs(10'h380, 3'b011, 2);
        send_trs(10'h240, 3'b100, 2);
        cfg(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        send_trs(10'h2C0, 3'b110, 4);
    endtask : test_trs

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            $display("mismatch run_length expected end seen hang");
            summarize();
        end
    end

    initial begin
        repeat (16) @(negedge clk_sys);
        test_modes();
        test_hvf();
        test_861();
        test_trs();
        summarize();
    end
endmodule : testbench
`default_nettype wire
